// file: dmacf_pkg.sv
// Purpose : constants shared by the dma channel enable and flag block
// Assumes : one system clock, registers reached over the 8-bit sfr port
// Notes   : sfr addresses below are the byte addresses on that port
//
// Notes on behaviour
// - seven enable bits, reset to zero
// - seven full-length flags, reset zero, bit-addressable
// - full flag sets at offset equals size-1
// - full interrupt enable comes from channel config
// - seven mid-point flags, bit 7 read-only
// - mid flag at size/2, or size/2+1 if odd
// - set flag holds off the channel's transfers
// - only enabled channels may transfer
`default_nettype none

package dmacf_pkg;

    // ------------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------------
    localparam int N_CHAN = 7;
    localparam int OFS_W  = 10;
    localparam int DATA_W = 8;

    // ------------------------------------------------------------------
    // sfr addresses and fields
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_CHAN_ENABLE = 8'h92;
    localparam logic [7:0] ADDR_FULL_FLAGS  = 8'hE8;
    localparam logic [7:0] ADDR_HALF_FLAGS  = 8'h88;
    localparam int         RSVD_BIT         = 7;
    localparam logic [6:0] RST_CHAN_BITS    = 7'h00;
    localparam logic [7:0] RST_RDATA        = 8'h00;

endpackage : dmacf_pkg

`default_nettype wire

// file: dmacf_chan_if.sv
// Purpose : per-channel progress and event signals between top and detector
// Assumes : all signals belong to the system clock domain
// Notes   : one instance per channel
`default_nettype none

interface dmacf_chan_if;
    logic                            byte_done;
    logic [dmacf_pkg::OFS_W-1:0]     offset;
    logic [dmacf_pkg::OFS_W-1:0]     size;
    logic                            full_evt;
    logic                            mid_evt;

    modport top (
        output byte_done,
        output offset,
        output size,
        input  full_evt,
        input  mid_evt
    );

    modport det (
        input  byte_done,
        input  offset,
        input  size,
        output full_evt,
        output mid_evt
    );
endinterface : dmacf_chan_if

`default_nettype wire

// file: dmacf_chan_det.sv
// Purpose : compare one channel's offset with its size on each byte moved
// Assumes : offset is the value of the byte just transferred
// Notes   : purely combinational; the flags are held in the top module
`default_nettype none

module dmacf_chan_det (
    dmacf_chan_if.det ch
);
    logic [dmacf_pkg::OFS_W-1:0] last_ofs;
    logic [dmacf_pkg::OFS_W-1:0] mid_ofs;

    always_comb begin
        last_ofs = dmacf_pkg::OFS_W'(ch.size - 10'h001);
        // odd sizes round the half point up by one
        if (ch.size[0]) begin
            mid_ofs = dmacf_pkg::OFS_W'((ch.size >> 1) + 10'h001);
        end else begin
            mid_ofs = dmacf_pkg::OFS_W'(ch.size >> 1);
        end
        ch.full_evt = ch.byte_done && (ch.offset == last_ofs);
        ch.mid_evt  = ch.byte_done && (ch.offset == mid_ofs);
    end
endmodule : dmacf_chan_det

`default_nettype wire

// file: dmacf_top.sv
// Purpose : channel enable register and full/mid-point flag registers
// Assumes : sfr strobes are one-cycle pulses synchronous to clk
// Notes   : read data is registered and appears one cycle after sfr_rd
`default_nettype none

module dmacf_top (
    // clock and reset
    input  wire logic                      clk,
    input  wire logic                      rst_n,
    // sfr byte access
    input  wire logic [7:0]                sfr_addr,
    input  wire logic                      sfr_wr,
    input  wire logic                      sfr_rd,
    input  wire logic [7:0]                sfr_wdata,
    output logic      [7:0]                sfr_rdata,
    // sfr bit access (bit-addressable flag registers)
    input  wire logic                      sfr_bit_wr,
    input  wire logic [7:0]                sfr_bit_addr,
    input  wire logic                      sfr_bit_val,
    // transfer pipeline progress, per channel
    input  wire logic [6:0]                byte_done,
    input  wire logic [6:0][9:0]           address_offset,
    input  wire logic [6:0][9:0]           transfer_size,
    // interrupt enables from each channel_config
    input  wire logic [6:0]                full_ie,
    input  wire logic [6:0]                mid_ie,
    // to the channel arbiter and cpu
    output logic      [6:0]                chan_allow,
    output logic      [6:0]                chan_enable_bit,
    output logic                           dma_irq
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [6:0] enable_r;
    logic [6:0] enable_nxt;
    logic [6:0] full_r;
    logic [6:0] full_nxt;
    logic [6:0] mid_r;
    logic [6:0] mid_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;

    logic [6:0] full_evt;
    logic [6:0] mid_evt;
    logic [6:0] done_gated;
    logic [6:0] irq_src;

    // ------------------------------------------------------------------
    // decode results
    // ------------------------------------------------------------------
    logic       wr_en_reg;
    logic       wr_full;
    logic       wr_mid;
    logic       bwr_full;
    logic       bwr_mid;
    logic [2:0] bit_idx;
    logic [6:0] full_bsel;
    logic [6:0] mid_bsel;
    logic [6:0] bit_fill;

    // ------------------------------------------------------------------
    // per-channel detectors
    // ------------------------------------------------------------------
    // a byte only counts while the channel may move data; a stray strobe
    // on a held-off channel must not raise a second flag
    assign done_gated = byte_done & chan_allow;

    for (genvar g = 0; g < dmacf_pkg::N_CHAN; g++) begin : g_chan
        dmacf_chan_if cif ();

        assign cif.byte_done = done_gated[g];
        assign cif.offset    = address_offset[g];
        assign cif.size      = transfer_size[g];
        assign full_evt[g]   = cif.full_evt;
        assign mid_evt[g]    = cif.mid_evt;

        // a bit write lands on one channel; the reserved bit matches none
        assign full_bsel[g]  = bwr_full && (bit_idx == 3'(g));
        assign mid_bsel[g]   = bwr_mid && (bit_idx == 3'(g));

        dmacf_chan_det u_det (
            .ch (cif)
        );
    end

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    always_comb begin
        bit_idx   = sfr_bit_addr[2:0];
        wr_en_reg = sfr_wr && (sfr_addr == dmacf_pkg::ADDR_CHAN_ENABLE);
        wr_full   = sfr_wr && (sfr_addr == dmacf_pkg::ADDR_FULL_FLAGS);
        wr_mid    = sfr_wr && (sfr_addr == dmacf_pkg::ADDR_HALF_FLAGS);
        // bit address: upper five bits pick the register, low three the bit;
        // the reserved bit is not stored, so a bit write to it is dropped
        bwr_full  = sfr_bit_wr
                    && (sfr_bit_addr[7:3] == dmacf_pkg::ADDR_FULL_FLAGS[7:3])
                    && (bit_idx != 3'(dmacf_pkg::RSVD_BIT));
        bwr_mid   = sfr_bit_wr
                    && (sfr_bit_addr[7:3] == dmacf_pkg::ADDR_HALF_FLAGS[7:3])
                    && (bit_idx != 3'(dmacf_pkg::RSVD_BIT));
        // the written value is spread over all channels, the select masks it
        bit_fill  = {7{sfr_bit_val}};
    end

    // ------------------------------------------------------------------
    // enable register
    // ------------------------------------------------------------------
    always_comb begin
        enable_nxt = enable_r;
        if (wr_en_reg) begin
            // bit 7 is not stored, so a stray 1 there has no effect
            enable_nxt = sfr_wdata[6:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            enable_r <= dmacf_pkg::RST_CHAN_BITS;
        end else begin
            enable_r <= enable_nxt;
        end
    end

    // ------------------------------------------------------------------
    // full-length flags
    // ------------------------------------------------------------------
    // flags change by software writes and are set by hardware events; hardware never clears
    always_comb begin
        full_nxt = full_r;
        if (wr_full) begin
            full_nxt = sfr_wdata[6:0];
        end else if (bwr_full) begin
            full_nxt = (full_r & ~full_bsel)
                     | (bit_fill & full_bsel);
        end
        // an event in the cycle of a clear still sets the flag
        full_nxt = full_nxt | full_evt;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            full_r <= dmacf_pkg::RST_CHAN_BITS;
        end else begin
            full_r <= full_nxt;
        end
    end

    // ------------------------------------------------------------------
    // mid-point flags
    // ------------------------------------------------------------------
    // a set mid flag holds the channel off just as a full flag does
    always_comb begin
        mid_nxt = mid_r;
        if (wr_mid) begin
            mid_nxt = sfr_wdata[6:0];
        end else if (bwr_mid) begin
            mid_nxt = (mid_r & ~mid_bsel)
                    | (bit_fill & mid_bsel);
        end
        // same priority as the full flags: the set wins over a clear
        mid_nxt = mid_nxt | mid_evt;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mid_r <= dmacf_pkg::RST_CHAN_BITS;
        end else begin
            mid_r <= mid_nxt;
        end
    end

    // ------------------------------------------------------------------
    // read path
    // ------------------------------------------------------------------
    always_comb begin
        rdata_nxt = rdata_r;
        if (sfr_rd) begin
            case (sfr_addr)
                dmacf_pkg::ADDR_CHAN_ENABLE: begin
                    rdata_nxt = {1'b0, enable_r};
                end
                dmacf_pkg::ADDR_FULL_FLAGS: begin
                    rdata_nxt = {1'b0, full_r};
                end
                dmacf_pkg::ADDR_HALF_FLAGS: begin
                    rdata_nxt = {1'b0, mid_r};
                end
                default: begin
                    rdata_nxt = dmacf_pkg::RST_RDATA;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // read data register
    // ------------------------------------------------------------------
    // holding the last value keeps the byte stable for a slow reader
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_r <= dmacf_pkg::RST_RDATA;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    // transfers stop while any flag of the channel waits for software
    assign chan_allow      = enable_r & ~full_r & ~mid_r;
    assign chan_enable_bit = enable_r;
    assign sfr_rdata       = rdata_r;

    // full enable is taken as delivered by the selected channel_config
    assign irq_src = (full_r & full_ie) | (mid_r & mid_ie);
    assign dma_irq = |irq_src;

endmodule : dmacf_top

`default_nettype wire

// file: dmacf_asserts.sv
// Purpose: port checks for dmacf_top
// Assumes: one clock, async active-low reset
// Notes: channel 0 stands in for all seven
`default_nettype none
module dmacf_asserts (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic sfr_bit_wr,
    input wire logic [6:0] byte_done,
    input wire logic [6:0][9:0] address_offset,
    input wire logic [6:0][9:0] transfer_size,
    input wire logic [6:0] full_ie,
    input wire logic [6:0] mid_ie,
    input wire logic [6:0] chan_allow,
    input wire logic [6:0] chan_enable_bit,
    input wire logic dma_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    sequence last0;
        byte_done[0] && chan_allow[0] &&
        address_offset[0] == transfer_size[0] - 10'h001;
    endsequence
    sequence half0;
        byte_done[0] && chan_allow[0] && address_offset[0] ==
        (transfer_size[0] >> 1) + {9'h000, transfer_size[0][0]};
    endsequence
    en_write_a: assert property (
        sfr_wr && sfr_addr == 8'h92 |=>
        chan_enable_bit == $past(sfr_wdata[6:0])) else $error("enable lost");
    en_readback_a: assert property (
        sfr_rd && !sfr_wr && sfr_addr == 8'h92 |=>
        sfr_rdata[6:0] == $past(chan_enable_bit)) else $error("bad readback");
    rsvd_read_a: assert property (
        sfr_rd |=> !sfr_rdata[7]) else $error("bit 7 read as one");
    full_hold_a: assert property (
        last0 |=> !chan_allow[0]) else $error("full flag missed");
    half_hold_a: assert property (
        half0 |=> !chan_allow[0]) else $error("mid flag missed");
    flag_keep_a: assert property (
        !chan_allow[0] && chan_enable_bit[0] && !sfr_wr && !sfr_bit_wr
        |=> !chan_allow[0]) else $error("flag cleared itself");
    allow_en_a: assert property (
        (chan_allow & ~chan_enable_bit) == 7'h00) else $error("allow w/o en");
    irq_off_a: assert property (
        full_ie == 7'h00 && mid_ie == 7'h00 |-> !dma_irq)
        else $error("irq while masked");
endmodule : dmacf_asserts
bind dmacf_top dmacf_asserts chk_u (.clk(clk), .rst_n(rst_n),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_bit_wr(sfr_bit_wr),
    .byte_done(byte_done), .address_offset(address_offset),
    .transfer_size(transfer_size), .full_ie(full_ie), .mid_ie(mid_ie),
    .chan_allow(chan_allow), .chan_enable_bit(chan_enable_bit),
    .dma_irq(dma_irq));
`default_nettype wire

// file: dmacf_feed.sv
// Purpose: transfer pipeline model offering bytes per channel
// Assumes: byte_done follows go one cycle later; an untaken byte keeps its offset until a later strobe is taken
// Notes: offset wraps to zero after the last byte
`default_nettype none
module dmacf_feed (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [6:0] go,
    input wire logic [6:0][9:0] size,
    input wire logic [6:0] chan_allow,
    output logic [6:0] byte_done,
    output logic [6:0][9:0] address_offset
);
    timeunit 1ns;
    timeprecision 1ps;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            byte_done <= '0;
            address_offset <= '0;
        end else begin
            for (int n = 0; n < 7; n++) begin
                // a held-off byte is not lost, only delayed
                if (byte_done[n] && chan_allow[n]) begin
                    address_offset[n] <= address_offset[n] + 10'h001;
                    if (address_offset[n] == size[n] - 10'h001)
                        address_offset[n] <= 10'h000;
                end
                byte_done[n] <= go[n];
            end
        end
    end
endmodule : dmacf_feed
`default_nettype wire

// file: tb_top.sv
// Purpose: self-checking bench for dmacf_top
// Assumes: 200 MHz clock, fixed seed
// Notes: channels are run one at a time
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_n, sfr_wr, sfr_rd, sfr_bit_wr, sfr_bit_val, dma_irq;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, sfr_bit_addr;
    logic [6:0] go, byte_done, full_ie, mid_ie, chan_allow, chan_en;
    logic [6:0][9:0] ofs, sz;
    int err_count, checked, nbytes, cur, cyc;
    dmacf_top dut_u (.clk(clk), .rst_n(rst_n), .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
        .sfr_rdata(sfr_rdata), .sfr_bit_wr(sfr_bit_wr),
        .sfr_bit_addr(sfr_bit_addr), .sfr_bit_val(sfr_bit_val),
        .byte_done(byte_done), .address_offset(ofs), .transfer_size(sz),
        .full_ie(full_ie), .mid_ie(mid_ie), .chan_allow(chan_allow),
        .chan_enable_bit(chan_en), .dma_irq(dma_irq));
    dmacf_feed feed_u (.clk(clk), .rst_n(rst_n), .go(go), .size(sz),
        .chan_allow(chan_allow), .byte_done(byte_done),
        .address_offset(ofs));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (byte_done[cur] && chan_allow[cur])
            nbytes++;
        if (cyc > 20000) begin
            err_count++;
            stop_test();
        end
    end
    function automatic int mid_of(input int s);
        return s / 2 + s % 2;
    endfunction : mid_of
    task automatic chk(input string nm, input logic [9:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, d);
        @(posedge clk);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge clk);
        sfr_wr <= 1'b0;
    endtask : wr
    task automatic bw(input logic [7:0] a, input logic v);
        @(posedge clk);
        sfr_bit_addr <= a;
        sfr_bit_val <= v;
        sfr_bit_wr <= 1'b1;
        @(posedge clk);
        sfr_bit_wr <= 1'b0;
    endtask : bw
    task automatic rd(input logic [7:0] a, exp);
        @(posedge clk);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge clk);
        sfr_rd <= 1'b0;
        @(negedge clk);
        chk($sformatf("reg %h", a), {2'h0, sfr_rdata}, {2'h0, exp});
    endtask : rd
    // random stalls; returns once the channel is held off, or after 300 cycles
    task automatic run(input int n);
        repeat (300) begin
            @(posedge clk);
            go <= ($urandom % 4 != 0) ? 7'h01 << n : 7'h00;
            #1;
            if (!chan_allow[n])
                break;
        end
        go <= 7'h00;
    endtask : run
    initial begin
        {sfr_wr, sfr_rd, sfr_bit_wr, sfr_bit_val, rst_n} = 5'h00;
        {sfr_addr, sfr_wdata, sfr_bit_addr} = 24'h000000;
        {go, full_ie, mid_ie} = '0;
        sz = '0;
        void'($urandom(66356));
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd(8'h92, 8'h00);
        rd(8'hE8, 8'h00);
        rd(8'h88, 8'h00);
        rd(8'h90, 8'h00);
        wr(8'h92, 8'h7F);
        rd(8'h92, 8'h7F);
        bw(8'hEF, 1'b0);
        rd(8'hE8, 8'h00);
        for (int n = 0; n < 7; n++) begin
            cur = n;
            nbytes = 0;
            @(posedge clk);
            sz[n] <= (n == 0) ? 10'h004 : 10'(4 + $urandom % 12);
            full_ie <= 7'($urandom);
            mid_ie <= 7'($urandom);
            wr(8'h92, 8'h01 << n);
            #1 chk("enable", {3'h0, chan_en}, 10'(8'h01 << n));
            run(n);
            chk("mid n", 10'(nbytes), 10'(mid_of(sz[n]) + 1));
            chk("mid irq", {9'h0, dma_irq}, {9'h0, mid_ie[n]});
            rd(8'h88, 8'h01 << n);
            if (n % 2) begin
                bw(8'h88 + 8'(n), 1'b0);
            end else begin
                wr(8'h88, 8'h00);
            end
            run(n);
            chk("full n", 10'(nbytes), sz[n]);
            chk("full irq", {9'h0, dma_irq}, {9'h0, full_ie[n]});
            rd(8'hE8, 8'h01 << n);
            wr(8'hE8, 8'h00);
            wr(8'h92, 8'h00);
            #1 chk("allow", {3'h0, chan_allow}, 10'h000);
        end
        stop_test();
    end
    task automatic stop_test();
        $display("checks %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : stop_test
endmodule : tb_top
`default_nettype wire
